// File: shared/boost_cfg.svh
`ifndef BOOST_CFG_SVH
`define BOOST_CFG_SVH

// clock and phase step timing
`define CLK_PERIOD_NS 50
`define PHASE_STEP_NS 65
`define PHASE_STEP_CYC ((`PHASE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// reset values of the configuration fields
`define MODE_RESET 2'h0
`define ENABLE_RESET 1'h1
`define CEIL_RESET 8'hA7
`define PFM_RESET 2'h0
`define STAGGER_RESET 1'h1
`define FROM_ADDR_RESET 1'h1
`define PHASE_RESET 2'h0
`define LIMIT_RESET 24'h000000

// legal ceiling code window
`define CEIL_MIN 8'h54
`define CEIL_MAX 8'hE5

// supply decision tuning, voltage codes in 33 mV steps
`define HEADROOM 9'h00A
`define HOLD_SAMPLES 8'h40

`endif

// File: shared/boost_pkg.sv
package boost_pkg;

   typedef enum logic [1:0] {
      MODE_TRACK = 2'h0,
      MODE_TWO_LEVEL = 2'h1,
      MODE_FORCED_ON = 2'h2,
      MODE_FORCED_OFF = 2'h3
   } conv_mode_t;

   typedef enum logic [1:0] {
      PFM_NONE = 2'h0,
      PFM_25K = 2'h1,
      PFM_50K = 2'h2,
      PFM_RSVD = 2'h3
   } pfm_floor_t;

   typedef enum logic {
      ST_BYPASS = 1'h0,
      ST_BOOST = 1'h1
   } supply_state_t;

   typedef logic [8:0] vcode_t;

endpackage

// File: verilog/phase_sync_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "boost_cfg.svh"

module phase_sync_gen (
   // clock and synchronised reset
   input wire logic clk,
   input wire logic rst_n,
   // frame sync pin, asynchronous
   input wire logic frame_pin,
   // phase control
   input wire logic stagger_en,
   input wire logic [1:0] phase_sel,
   // switching phase reference to the power stage
   output logic sync_pulse
);

   logic fs_s1;
   logic fs_s2;
   logic fs_s3;
   logic fs_lvl;
   logic frame_edge;
   logic [2:0] dly;
   logic [2:0] cnt;

   function automatic logic [2:0] delay_cycles(input logic [1:0] sel);
      logic [2:0] step;
      step = 3'(`PHASE_STEP_CYC);
      return 3'({1'h0, sel} * step);
   endfunction

   // the first stage only feeds the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fs_s1 <= 1'h0;
         fs_s2 <= 1'h0;
         fs_s3 <= 1'h0;
      end else begin
         fs_s1 <= frame_pin;
         fs_s2 <= fs_s1;
         fs_s3 <= fs_s2;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fs_lvl <= 1'h0;
      end else if (fs_s2 == fs_s3) begin
         fs_lvl <= fs_s3;
      end
   end

   assign frame_edge = (fs_s2 == fs_s3) && fs_s3 && !fs_lvl; // R16
   assign dly = delay_cycles(phase_sel); // R15

   // 65 ns steps round up to whole 50 ns cycles at this clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 3'h0;
      end else if (frame_edge) begin
         cnt <= dly; // R19
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1; // R19
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_pulse <= 1'h0;
      end else begin
         sync_pulse <= stagger_en &&
            ((frame_edge && dly == 3'h0) || (!frame_edge && cnt == 3'h1)); // R13
      end
   end

   a_no_stagger: assert property (@(posedge clk) disable iff (!rst_n)
      !stagger_en |=> !sync_pulse) // R13
      else $error("phase pulse while staggering disabled");
   a_zero_phase: assert property (@(posedge clk) disable iff (!rst_n)
      frame_edge && stagger_en && dly == 3'h0 |=> sync_pulse) // R16
      else $error("zero phase pulse not one cycle after frame edge");
   a_step_delay: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_edge && dly == 3'h2) ##1 (stagger_en && !frame_edge) [*3]
      |-> sync_pulse) // R19
      else $error("one step phase pulse late or missing");
   a_last_phase: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_edge && dly == 3'h6) ##1 (stagger_en && !frame_edge) [*7]
      |-> sync_pulse && !$past(sync_pulse)) // R15
      else $error("three step phase pulse late or missing");

endmodule

`default_nettype wire

// File: verilog/boost_mode_phase_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "boost_cfg.svh"

// How it works
// R1: mode field picks tracking, two-level, forced on or forced off bypass.
// R2: automatic modes compare upcoming audio need against battery and start boost early.
// R3: after need disappears for a hold window, boost stops and battery bypasses.
// R4: two-level mode only switches on or off, on means ceiling voltage.
// R5: tracking target sits just above audio need in 33 mV steps.
// R6: tracking target never exceeds the ceiling code voltage.
// R7: enable bit zero disables converter for external supply; reset value one.
// R8: ceiling code is 66 mV per count, reserved codes flagged and clamped.
// R9: light-load floor none, 25 kHz or 50 kHz; reserved code treated as none.
// R10: 24-bit peak current limit is handed to the power stage.
// R11: software keeps the limit below about 95 percent of inductor saturation.
// R12: software retunes tracking coefficients after limit or ceiling changes.
// R13: stagger enable offsets switching phase so devices do not peak together.
// R14: address-derived bit picks phase from bus address, else manual field.
// R15: manual phase delays switching by 0, 65, 130 or 195 ns; code rounds each step to 2 cycles, giving 0, 100, 200 or 300 ns.
// R16: phase offset counts from frame sync shared by all devices.
// R17: with external supply software clears enable and leaves switch node open.
// R18: enable zero keeps converter off whatever mode, ceiling or phase say.
// R19: phase delay is counted from each frame sync edge in clock cycles.
module boost_mode_phase_control
   import boost_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // software configuration fields
   input wire logic [1:0] CONVERTER_MODE_SEL,
   input wire logic CONVERTER_ENABLE_BIT,
   input wire logic [7:0] CONVERTER_CEILING_CODE,
   input wire logic [1:0] PFM_FLOOR_SEL,
   input wire logic [23:0] INDUCTOR_PEAK_LIMIT,
   input wire logic PHASE_STAGGER_EN,
   input wire logic PHASE_FROM_ADDR,
   input wire logic [1:0] PHASE_MANUAL_SEL,
   // detected bus target address offset
   input wire logic [1:0] TARGET_ADDR_OFS,
   // frame sync pin
   input wire logic FRAME_SYNC,
   // look-ahead audio demand and battery level, 33 mV codes
   input wire logic SAMPLE_VALID,
   input wire logic [8:0] SAMPLE_NEED,
   input wire logic [8:0] BATTERY_LEVEL,
   // to the power stage
   output logic BOOST_ON,
   output logic BYPASS_ON,
   output logic [8:0] BOOST_TARGET,
   output logic [1:0] PFM_FLOOR,
   output logic [23:0] PEAK_LIMIT,
   output logic SWITCH_SYNC,
   output logic CEILING_RESERVED
);

   logic rst_q1;
   logic rst_n_sync;

   conv_mode_t cfg_mode;
   logic cfg_en;
   logic [7:0] cfg_ceil;
   pfm_floor_t cfg_pfm;
   logic [23:0] cfg_ilim;
   logic cfg_stagger;
   logic cfg_from_addr;
   logic [1:0] cfg_phase;
   logic [1:0] cfg_addr;

   supply_state_t state;
   supply_state_t next_state;
   logic [7:0] hold_cnt;
   vcode_t track_req;
   vcode_t next_track;
   vcode_t req;
   vcode_t ceil_code;
   logic auto_mode;
   logic need_now;
   logic release_now;
   logic next_on;
   logic [1:0] phase_sel;

   function automatic logic [7:0] legal_ceiling(input logic [7:0] code);
      if (code < `CEIL_MIN) begin
         return `CEIL_MIN;
      end else if (code > `CEIL_MAX) begin
         return `CEIL_MAX;
      end
      return code;
   endfunction

   // one ceiling count is two tracking steps
   function automatic vcode_t ceiling_volts(input logic [7:0] code);
      return {legal_ceiling(code), 1'h0};
   endfunction

   function automatic vcode_t min_code(input vcode_t a, input vcode_t b);
      return (a < b) ? a : b;
   endfunction

   function automatic vcode_t max_code(input vcode_t a, input vcode_t b);
      return (a > b) ? a : b;
   endfunction

   // saturating add keeps a loud sample from wrapping to a tiny target
   function automatic vcode_t required(input vcode_t need);
      logic [9:0] sum;
      sum = {1'h0, need} + {1'h0, `HEADROOM};
      return sum[9] ? 9'h1FF : sum[8:0];
   endfunction

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_q1 <= 1'h0;
         rst_n_sync <= 1'h0;
      end else begin
         rst_q1 <= 1'h1;
         rst_n_sync <= rst_q1;
      end
   end

   // configuration copies hold their power-on defaults through reset
   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         cfg_mode <= conv_mode_t'(`MODE_RESET);
         cfg_en <= `ENABLE_RESET;
         cfg_ceil <= `CEIL_RESET;
         cfg_pfm <= pfm_floor_t'(`PFM_RESET);
         cfg_ilim <= `LIMIT_RESET;
         cfg_stagger <= `STAGGER_RESET;
         cfg_from_addr <= `FROM_ADDR_RESET;
         cfg_phase <= `PHASE_RESET;
         cfg_addr <= 2'h0;
      end else begin
         cfg_mode <= conv_mode_t'(CONVERTER_MODE_SEL);
         cfg_en <= CONVERTER_ENABLE_BIT;
         cfg_ceil <= CONVERTER_CEILING_CODE;
         cfg_pfm <= pfm_floor_t'(PFM_FLOOR_SEL);
         cfg_ilim <= INDUCTOR_PEAK_LIMIT;
         cfg_stagger <= PHASE_STAGGER_EN;
         cfg_from_addr <= PHASE_FROM_ADDR;
         cfg_phase <= PHASE_MANUAL_SEL;
         cfg_addr <= TARGET_ADDR_OFS;
      end
   end

   assign auto_mode = (cfg_mode == MODE_TRACK) || (cfg_mode == MODE_TWO_LEVEL); // R1
   assign req = required(SAMPLE_NEED); // R5
   assign ceil_code = ceiling_volts(cfg_ceil); // R8
   assign need_now = SAMPLE_VALID && (req > BATTERY_LEVEL); // R2
   assign release_now = SAMPLE_VALID && !need_now && (hold_cnt == 8'h01); // R3

   // hold window counted in samples, so silence between frames does not count
   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         hold_cnt <= 8'h00;
      end else if (!cfg_en || !auto_mode) begin
         hold_cnt <= 8'h00;
      end else if (need_now) begin
         hold_cnt <= `HOLD_SAMPLES; // R3
      end else if (SAMPLE_VALID && hold_cnt != 8'h00) begin
         hold_cnt <= hold_cnt - 8'h01;
      end
   end

   always_comb begin
      next_state = state;
      if (!cfg_en || !auto_mode) begin
         next_state = ST_BYPASS; // R18
      end else begin
         case (state)
            ST_BYPASS: begin
               if (need_now) begin
                  next_state = ST_BOOST; // R2
               end
            end
            ST_BOOST: begin
               if (release_now) begin
                  next_state = ST_BYPASS; // R3
               end
            end
            default: begin
               next_state = ST_BYPASS;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         state <= ST_BYPASS;
      end else begin
         state <= next_state;
      end
   end

   // tracking holds the loudest need of the window, then falls back
   always_comb begin
      next_track = track_req;
      if (next_state == ST_BYPASS) begin
         next_track = 9'h000; // R3
      end else if (need_now) begin
         next_track = max_code(track_req, req); // R5
      end else if (release_now) begin
         next_track = 9'h000;
      end
   end

   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         track_req <= 9'h000;
      end else begin
         track_req <= next_track;
      end
   end

   always_comb begin
      next_on = 1'h0;
      if (cfg_en) begin // R7
         case (cfg_mode)
            MODE_TRACK: next_on = (next_state == ST_BOOST); // R1
            MODE_TWO_LEVEL: next_on = (next_state == ST_BOOST); // R4
            MODE_FORCED_ON: next_on = 1'h1; // R1
            MODE_FORCED_OFF: next_on = 1'h0; // R1
            default: next_on = 1'h0;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         BOOST_ON <= 1'h0;
         BYPASS_ON <= 1'h1;
      end else begin
         BOOST_ON <= next_on; // R18
         BYPASS_ON <= !next_on; // R3
      end
   end

   // forced-on has no audio-derived target, so it runs at the ceiling
   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         BOOST_TARGET <= 9'h000;
      end else if (!next_on) begin
         BOOST_TARGET <= 9'h000; // R18
      end else if (cfg_mode == MODE_TRACK) begin
         BOOST_TARGET <= min_code(next_track, ceil_code); // R6
      end else begin
         BOOST_TARGET <= ceil_code; // R4
      end
   end

   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         CEILING_RESERVED <= 1'h0;
      end else begin
         CEILING_RESERVED <= (cfg_ceil < `CEIL_MIN) || (cfg_ceil > `CEIL_MAX); // R8
      end
   end

   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         PFM_FLOOR <= `PFM_RESET;
      end else if (cfg_pfm == PFM_RSVD) begin
         PFM_FLOOR <= PFM_NONE; // R9
      end else begin
         PFM_FLOOR <= cfg_pfm; // R9
      end
   end

   // the limit scaling lives in the analog stage; only the code passes here
   always_ff @(posedge CLK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         PEAK_LIMIT <= `LIMIT_RESET;
      end else begin
         PEAK_LIMIT <= cfg_ilim; // R10
      end
   end

   assign phase_sel = cfg_from_addr ? cfg_addr : cfg_phase; // R14

   phase_sync_gen u_phase (
      .clk(CLK),
      .rst_n(rst_n_sync),
      .frame_pin(FRAME_SYNC),
      .stagger_en(cfg_stagger),
      .phase_sel(phase_sel),
      .sync_pulse(SWITCH_SYNC)
   );

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!rst_n_sync);

   a_forced_modes: assert property (
      cfg_en && cfg_mode == MODE_FORCED_ON ##1 cfg_mode == MODE_FORCED_OFF
      |-> BOOST_ON ##1 (BYPASS_ON && !BOOST_ON)) // R1
      else $error("forced mode did not steer the converter");
   a_need_turns_on: assert property (
      cfg_en && auto_mode && need_now |=> BOOST_ON && !BYPASS_ON) // R2
      else $error("boost not started on audio need");
   a_idle_releases: assert property (
      cfg_en && auto_mode && state == ST_BOOST && release_now
      |=> BYPASS_ON && !BOOST_ON) // R3
      else $error("boost not released after hold window");
   a_two_level_ceiling: assert property (
      cfg_en && cfg_mode == MODE_TWO_LEVEL && next_on
      |=> BOOST_TARGET == $past(ceil_code)) // R4
      else $error("two-level target differs from ceiling");
   a_track_above_need: assert property (
      cfg_en && cfg_mode == MODE_TRACK && need_now && req <= ceil_code
      |=> BOOST_TARGET >= $past(req)) // R5
      else $error("tracking target below audio need");
   a_ceiling_cap: assert property (
      BOOST_ON |-> BOOST_TARGET <= $past(ceil_code)) // R6
      else $error("target above ceiling");
   a_enable_gate: assert property (
      !cfg_en [*2] |-> !BOOST_ON && BYPASS_ON) // R7
      else $error("converter on while disabled");
   a_reserved_ceiling: assert property (
      cfg_ceil < `CEIL_MIN |=> CEILING_RESERVED ##0
      (!BOOST_ON || BOOST_TARGET == {`CEIL_MIN, 1'h0}
      || $past(cfg_mode) == MODE_TRACK)) // R8
      else $error("reserved low ceiling not flagged or clamped");
   a_pfm_reserved: assert property (
      cfg_pfm == PFM_RSVD |=> PFM_FLOOR == PFM_NONE) // R9
      else $error("reserved floor code passed through");
   a_limit_follows: assert property (
      $changed(cfg_ilim) |=> PEAK_LIMIT == $past(cfg_ilim)) // R10
      else $error("peak limit did not follow setting");
   a_phase_source: assert property (
      !cfg_from_addr |-> phase_sel == cfg_phase) // R14
      else $error("address used while manual phase selected");
   a_off_any_mode: assert property (
      !cfg_en |=> BOOST_TARGET == 9'h000 && state == ST_BYPASS) // R18
      else $error("disabled converter still has a target");

   c_track_boost: cover property (
      cfg_mode == MODE_TRACK && need_now ##1 BOOST_ON);
   c_two_level: cover property (
      cfg_mode == MODE_TWO_LEVEL && BOOST_ON);
   c_release: cover property (
      BOOST_ON ##1 BYPASS_ON && cfg_en && auto_mode);
   c_phase_pulse: cover property (
      cfg_stagger && phase_sel == 2'h3 && SWITCH_SYNC);

endmodule

`default_nettype wire

// File: tb/supply_model.sv
`timescale 1ns/1ps
`default_nettype none

module supply_model #(
   parameter logic [23:0] SAT_CODE = 24'h000100
) (
   // battery side
   input wire logic [8:0] battery_set,
   output logic [8:0] battery_level,
   // converter side
   input wire logic boost_on,
   input wire logic bypass_on,
   input wire logic [8:0] boost_target,
   input wire logic [23:0] peak_limit,
   // observed rail and limit margin
   output logic [8:0] rail_level,
   output logic limit_ok
);
   // a battery is always driven, so its level never floats
   assign battery_level = battery_set;
   // rail follows the battery in bypass, the target while boosting
   assign rail_level = bypass_on ? battery_set : (boost_on ? boost_target : 9'h000);
   // margin of 5 percent kept below inductor saturation
   assign limit_ok = (32'(peak_limit) * 32'h64) <= (32'(SAT_CODE) * 32'h5F);
endmodule

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
   import boost_pkg::*;
;
   logic clk, rst_n, en, stag, from_addr, frame_sync, valid;
   logic [1:0] mode, pfm_sel, man, addr, pfm;
   logic [7:0] ceil;
   logic [23:0] limit, peak;
   logic [8:0] need, vbat_set, vbat, target, rail;
   logic boost_on, bypass_on, phase_ref, ceil_rsv, lim_ok;
   logic [7:0] ctab [7] = '{8'h53, 8'h54, 8'hA7, 8'hE0, 8'hE5, 8'hE6, 8'hFF};
   logic [8:0] ttab [7] = '{9'h0A8, 9'h0A8, 9'h14E, 9'h1C0, 9'h1CA, 9'h1CA, 9'h1CA};
   logic rtab [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   int bad_count = 0;
   int n_tests = 0;
   int base, n, w;

   boost_mode_phase_control uut (
      .CLK(clk), .RST_N(rst_n),
      .CONVERTER_MODE_SEL(mode), .CONVERTER_ENABLE_BIT(en),
      .CONVERTER_CEILING_CODE(ceil), .PFM_FLOOR_SEL(pfm_sel),
      .INDUCTOR_PEAK_LIMIT(limit), .PHASE_STAGGER_EN(stag),
      .PHASE_FROM_ADDR(from_addr), .PHASE_MANUAL_SEL(man),
      .TARGET_ADDR_OFS(addr), .FRAME_SYNC(frame_sync),
      .SAMPLE_VALID(valid), .SAMPLE_NEED(need), .BATTERY_LEVEL(vbat),
      .BOOST_ON(boost_on), .BYPASS_ON(bypass_on), .BOOST_TARGET(target),
      .PFM_FLOOR(pfm), .PEAK_LIMIT(peak), .SWITCH_SYNC(phase_ref),
      .CEILING_RESERVED(ceil_rsv)
   );

   supply_model model (
      .battery_set(vbat_set), .battery_level(vbat),
      .boost_on(boost_on), .bypass_on(bypass_on), .boost_target(target),
      .peak_limit(peak), .rail_level(rail), .limit_ok(lim_ok)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // config needs a copy edge and an output edge
   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   // leaves the caller a cycle and a half after the edge that answers the sample
   task automatic sample(input logic [8:0] v);
      valid = 1'b1;
      need = v;
      @(negedge clk);
      valid = 1'b0;
      @(negedge clk);
   endtask

   // frames stay well over 7 cycles apart
   task automatic frame(output int first, output int width);
      first = -1;
      width = 0;
      frame_sync = 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(negedge clk);
         if (phase_ref === 1'b1) begin
            width++;
            if (first < 0) first = i;
         end
      end
      frame_sync = 1'b0;
      repeat (10) @(negedge clk);
   endtask

   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      $display("mismatch watchdog expected finish seen timeout");
      end_of_test();
   end

   initial begin
      rst_n = 1'b0;
      mode = MODE_TRACK;
      en = 1'b1;
      ceil = 8'hA7;
      pfm_sel = 2'h0;
      limit = 24'h0000A5;
      stag = 1'b1;
      from_addr = 1'b1;
      man = 2'h0;
      addr = 2'h0;
      frame_sync = 1'b0;
      valid = 1'b0;
      need = 9'h000;
      vbat_set = 9'h064;
      repeat (4) @(negedge clk);
      chk("reset boost", 24'h0, 24'(boost_on));
      chk("reset bypass", 24'h1, 24'(bypass_on));
      chk("reset target", 24'h0, 24'(target));
      chk("reset sync", 24'h0, 24'(phase_ref));
      chk("reset reserved", 24'h0, 24'(ceil_rsv));
      @(negedge clk);
      rst_n = 1'b1;
      // two release flops, a copy edge and an output edge
      repeat (4) @(negedge clk);
      chk("peak limit", 24'h0000A5, peak);
      chk("limit margin", 24'h1, 24'(lim_ok));
      $display("test reset done");

      sample(9'h05F);
      chk("track boost", 24'h1, 24'(boost_on));
      chk("track bypass", 24'h0, 24'(bypass_on));
      chk("track target", 24'h069, 24'(target));
      sample(9'h0C8);
      chk("track raise", 24'h0D2, 24'(target));
      // tracking coefficients would be rewritten here by software
      ceil = 8'h54;
      settle();
      chk("track cap", 24'h0A8, 24'(target));
      valid = 1'b1;
      need = 9'h000;
      repeat (63) @(negedge clk);
      chk("hold boost", 24'h1, 24'(boost_on));
      @(negedge clk);
      valid = 1'b0;
      chk("release boost", 24'h0, 24'(boost_on));
      chk("release bypass", 24'h1, 24'(bypass_on));
      chk("release target", 24'h0, 24'(target));
      chk("rail battery", 24'h064, 24'(rail));
      $display("test tracking done");

      mode = MODE_TWO_LEVEL;
      ceil = 8'h60;
      settle();
      sample(9'h05F);
      chk("two level boost", 24'h1, 24'(boost_on));
      chk("two level target", 24'h0C0, 24'(target));
      en = 1'b0;
      settle();
      chk("disabled boost", 24'h0, 24'(boost_on));
      chk("disabled bypass", 24'h1, 24'(bypass_on));
      chk("disabled target", 24'h0, 24'(target));
      mode = MODE_FORCED_ON;
      settle();
      sample(9'h0C8);
      chk("disabled forced", 24'h0, 24'(boost_on));
      en = 1'b1;
      settle();
      chk("forced on", 24'h1, 24'(boost_on));
      $display("test two level and enable done");

      for (int i = 0; i < 7; i++) begin
         ceil = ctab[i];
         settle();
         chk("ceiling target", 24'(ttab[i]), 24'(target));
         chk("ceiling reserved", 24'(rtab[i]), 24'(ceil_rsv));
      end
      mode = MODE_FORCED_OFF;
      settle();
      sample(9'h0C8);
      chk("forced off boost", 24'h0, 24'(boost_on));
      chk("forced off bypass", 24'h1, 24'(bypass_on));
      $display("test ceiling and modes done");

      for (int i = 0; i < 4; i++) begin
         pfm_sel = 2'(i);
         settle();
         chk("pfm floor", (i == 3) ? 24'h0 : 24'(i), 24'(pfm));
      end
      $display("test pfm floor done");

      // one shared frame sync reaches every device
      from_addr = 1'b0;
      for (int i = 0; i < 4; i++) begin
         man = 2'(i);
         settle();
         frame(n, w);
         if (i == 0) base = n;
         chk("manual phase", 24'(2 * i), 24'(n - base));
         chk("pulse width", 24'h1, 24'(w));
      end
      from_addr = 1'b1;
      addr = 2'h3;
      man = 2'h0;
      settle();
      frame(n, w);
      chk("address phase", 24'h6, 24'(n - base));
      stag = 1'b0;
      settle();
      frame(n, w);
      chk("stagger off", 24'h0, 24'(w));
      $display("test phase done");
      end_of_test();
   end
endmodule

`default_nettype wire
